// File: pkg/tsr_pkg.sv
package tsr_pkg;

  // Link framing
  localparam int unsigned TSR_READ_BITS   = 16;
  localparam int unsigned TSR_FRAME_BITS  = 32;
  localparam int unsigned TSR_CFG_BITS    = 8;

  // Configuration codes seen in the low byte
  localparam logic [7:0]  TSR_CODE_SHUTDOWN = 8'hff;
  localparam logic [7:0]  TSR_CODE_CONVERT  = 8'h00;

  // Value driven in the two lowest bit positions
  localparam logic [1:0]  TSR_LOW_ONES      = 2'h3;

  // Reset values
  localparam logic        TSR_RST_SHUTDOWN  = 1'b0;
  localparam logic [13:0] TSR_RST_TEMP      = 14'h0000;
  localparam logic [5:0]  TSR_RST_COUNT     = 6'h00;
  localparam logic [7:0]  TSR_RST_CFG       = 8'h00;

  typedef struct packed {
    logic [13:0] data;
    logic [1:0]  ones;
  } tsr_word_t;

  localparam tsr_word_t   TSR_RST_WORD      = '{data: 14'h0000, ones: 2'h3};

endpackage

// File: rtl/tsr_top.sv
`timescale 1ns/1ns
// Function
// - Three registers: temperature and identity read only, configuration write only.
// - Configuration is sixteen bits; only the low byte selects the mode.
// - Low byte all ones enters shutdown.
// - Low byte all zeros enters continuous conversion.
// - Two lowest bit positions of both readable words are driven as one.
// - Temperature sits in bits 15 to 2, two's complement, 1/32 degree steps.
// - In shutdown a read returns the identity word instead of temperature.
// - Data shifts out on falling clock edges, is sampled on rising edges.
// - Frame is 16 read clocks, optionally 16 write clocks, select held low.
// - Write bits enter an 8-bit shift register; last eight count.
// - Every frame end, read-only ones too, pulses conv_restart outside shutdown; output word reloads while the synchronised select is high.
module tsr_top
  import tsr_pkg::*;
#(
  parameter logic [13:0] ID_CODE = 14'h2a5a  // Arbitrary identity value
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        serial_shift_clock,
  input  wire logic        sel_b,
  input  wire logic        sio_in,
  output      logic        sio_out,
  output      logic        sio_oe,
  input  wire logic [13:0] conv_result,
  input  wire logic        conv_done,
  output      logic        conv_restart,
  output      logic        shutdown
);

  // ==========================================================================
  // Link domain: frame counters and configuration shifter
  // ==========================================================================
  logic        link_rst;
  logic        frame_rst_b;
  logic [5:0]  rise_cnt_ff;
  logic [5:0]  nxt_rise_cnt;
  logic [4:0]  fall_cnt_ff;
  logic [4:0]  nxt_fall_cnt;
  logic [7:0]  cfg_shift_ff;
  logic [7:0]  nxt_cfg_shift;
  logic        cfg_seen_ff;
  logic        nxt_cfg_seen;
  tsr_word_t   out_word_ff;
  tsr_word_t   nxt_out_word;

  assign link_rst    = ~rst_b;
  assign frame_rst_b = rst_b & ~sel_b;

  always_comb
  begin
    nxt_rise_cnt  = rise_cnt_ff;
    nxt_cfg_shift = cfg_shift_ff;
    nxt_cfg_seen  = cfg_seen_ff;
    if (rise_cnt_ff < 6'(TSR_FRAME_BITS))
    begin
      nxt_rise_cnt = rise_cnt_ff + 6'h01;
    end
    if (rise_cnt_ff == TSR_RST_COUNT)
    begin
      nxt_cfg_seen = 1'b0;
    end
    if ((rise_cnt_ff >= 6'(TSR_READ_BITS)) && (rise_cnt_ff < 6'(TSR_FRAME_BITS)))
    begin
      nxt_cfg_shift = {cfg_shift_ff[6:0], sio_in};
      nxt_cfg_seen  = 1'b1;
    end
  end

  // Frame counter clears while select is high
  always_ff @(posedge serial_shift_clock or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      rise_cnt_ff <= TSR_RST_COUNT;
    end
    else
    begin
      rise_cnt_ff <= nxt_rise_cnt;
    end
  end

  always_ff @(posedge serial_shift_clock or posedge link_rst)
  begin
    if (link_rst)
    begin
      cfg_shift_ff <= TSR_RST_CFG;
      cfg_seen_ff  <= 1'b0;
    end
    else
    begin
      cfg_shift_ff <= nxt_cfg_shift;
      cfg_seen_ff  <= nxt_cfg_seen;
    end
  end

  always_comb
  begin
    nxt_fall_cnt = fall_cnt_ff;
    if (fall_cnt_ff < 5'(TSR_READ_BITS))
    begin
      nxt_fall_cnt = fall_cnt_ff + 5'h01;
    end
  end

  always_ff @(negedge serial_shift_clock or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      fall_cnt_ff <= 5'h00;
    end
    else
    begin
      fall_cnt_ff <= nxt_fall_cnt;
    end
  end

  // MSB first; pin released after the read phase and while deselected
  always_comb
  begin
    sio_out = 1'b1;
    if (fall_cnt_ff < 5'(TSR_READ_BITS))
    begin
      sio_out = out_word_ff[4'(15 - fall_cnt_ff[3:0])];
    end
    sio_oe = ~sel_b & (fall_cnt_ff < 5'(TSR_READ_BITS));
  end

  // ==========================================================================
  // System domain: select synchroniser, mode, output word
  // ==========================================================================
  logic        sel_meta_ff;
  logic        sel_sync_ff;
  logic        sel_prev_ff;
  logic        frame_end;
  logic        shutdown_ff;
  logic        nxt_shutdown;
  logic        restart_ff;
  logic        nxt_restart;
  logic [13:0] temp_ff;
  logic [13:0] nxt_temp;

  assign frame_end = sel_sync_ff & ~sel_prev_ff;

  always_comb
  begin
    nxt_shutdown = shutdown_ff;
    nxt_restart  = 1'b0;
    nxt_temp     = temp_ff;
    nxt_out_word = out_word_ff;
    if (conv_done)
    begin
      nxt_temp = conv_result;
    end
    // Low byte alone decides; any other code leaves the mode alone
    if (frame_end && cfg_seen_ff)
    begin
      if (cfg_shift_ff == TSR_CODE_SHUTDOWN)
      begin
        nxt_shutdown = 1'b1;
      end
      else if (cfg_shift_ff == TSR_CODE_CONVERT)
      begin
        nxt_shutdown = 1'b0;
      end
    end
    if (frame_end)
    begin
      nxt_restart = ~nxt_shutdown;
    end
    // Word reloads while synchronised select is high, so also for two clocks after select falls
    if (sel_sync_ff)
    begin
      nxt_out_word.ones = TSR_LOW_ONES;
      nxt_out_word.data = shutdown_ff ? ID_CODE : temp_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_meta_ff <= 1'b1;
      sel_sync_ff <= 1'b1;
      sel_prev_ff <= 1'b1;
      shutdown_ff <= TSR_RST_SHUTDOWN;
      restart_ff  <= 1'b0;
      temp_ff     <= TSR_RST_TEMP;
      out_word_ff <= TSR_RST_WORD;
    end
    else
    begin
      sel_meta_ff <= sel_b;
      sel_sync_ff <= sel_meta_ff;
      sel_prev_ff <= sel_sync_ff;
      shutdown_ff <= nxt_shutdown;
      restart_ff  <= nxt_restart;
      temp_ff     <= nxt_temp;
      out_word_ff <= nxt_out_word;
    end
  end

  assign shutdown     = shutdown_ff;
  assign conv_restart = restart_ff;

endmodule

// File: dv/tsr_monitor.sv
`timescale 1ns/1ns
// ========
// Mode and pin checks
module tsr_monitor(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sel_b,
  input wire logic sio_oe,
  input wire logic conv_restart,
  input wire logic shutdown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_end;
    $rose(sel_b);
  endsequence
  a_oe_idle: assert property (sel_b |-> !sio_oe)
    else $error("pin driven idle");
  a_oe_start: assert property ($fell(sel_b) |-> sio_oe)
    else $error("first bit missing");
  a_mode_frame: assert property (!sel_b |=> $stable(shutdown))
    else $error("mode moved in frame");
  a_mode_late: assert property (s_end |-> $stable(shutdown))
    else $error("mode moved early");
  a_shut_rise: assert property ($rose(shutdown) |-> sel_b)
    else $error("shutdown mid frame");
  a_restart_one: assert property (conv_restart |=> !conv_restart)
    else $error("restart too long");
  a_restart_idle: assert property (conv_restart |-> sel_b)
    else $error("restart mid frame");
  a_quiet_shut: assert property (shutdown && $past(shutdown) |-> !conv_restart)
    else $error("restart in shutdown");
endmodule
bind tsr_top tsr_monitor mon(.*);

// File: dv/tsr_host.sv
`timescale 1ns/1ns
// ========
// Host side of the link
module tsr_host(
  output logic      sc,
  output logic      sel_b,
  output logic      hd,
  input  wire logic sio
);
  initial
  begin
    sc = 0;
    sel_b = 1;
    hd = 0;
  end
  task automatic xfer(input logic [15:0] wr, input int nw, output logic [15:0] q);
    sel_b = 0;
    #20;
    for (int i = 0; i < 16 + nw; i++)
    begin
      if (i < 16)
        hd = ~hd;
      else
        hd = wr[nw + 15 - i];
      #6 sc = 1;
      if (i < 16) q[15 - i] = sio;
      #6 sc = 0;
    end
    hd = ~hd;
    #20 sel_b = 1;
    #200;
  endtask
endmodule

// File: dv/temp_sensor_register_file_bench.sv
`timescale 1ns/1ns
// ========
// Bench
module temp_sensor_register_file_bench;
  import tsr_pkg::*;
  localparam logic [13:0] ID = 14'h1234; // Arbitrary identity value
  logic        clk = 0;
  logic        rst_b = 0;
  logic        conv_done = 0;
  logic [13:0] conv_result = 14'h0000;
  logic        sc, sel_b, hd, sio_out, sio_oe, conv_restart, shutdown;
  logic [15:0] q;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_restart = 0;
  wire         sio = sio_oe ? sio_out : hd;
  always #4 clk = ~clk;
  tsr_top #(.ID_CODE(ID)) dut(.clk(clk), .rst_b(rst_b), .serial_shift_clock(sc),
    .sel_b(sel_b), .sio_in(sio), .sio_out(sio_out), .sio_oe(sio_oe),
    .conv_result(conv_result), .conv_done(conv_done), .conv_restart(conv_restart),
    .shutdown(shutdown));
  tsr_host host(.sc(sc), .sel_b(sel_b), .hd(hd), .sio(sio));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk)
    if (conv_restart === 1'b1)
      n_restart++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  task automatic t_temp();
    @(negedge clk) conv_result = 14'h2001;
    conv_done = 1;
    @(negedge clk) conv_done = 0;
    repeat (4) @(negedge clk);
    host.xfer(16'h0000, 0, q);
    cmp(q, 16'h8007);
    cmp(16'(n_restart), 16'h0001);
    $display("temperature test done");
  endtask
  task automatic t_mode();
    host.xfer(16'ha5ff, 16, q);
    cmp(q, 16'h8007);
    cmp({15'h0, shutdown}, 16'h0001);
    host.xfer(16'h5aff, 16, q);
    cmp(q, {ID, 2'h3});
    cmp({15'h0, shutdown}, 16'h0001);
    cmp(16'(n_restart), 16'h0001);
    host.xfer(16'hff00, 16, q);
    cmp(q, {ID, 2'h3});
    cmp({15'h0, shutdown}, 16'h0000);
    host.xfer(16'h00ff, 8, q);
    cmp(q, 16'h8007);
    cmp({15'h0, shutdown}, 16'h0001);
    host.xfer(16'h0000, 0, q);
    cmp(q, {ID, 2'h3});
    cmp({15'h0, shutdown}, 16'h0001);
    host.xfer(16'h0000, 8, q);
    cmp(q, {ID, 2'h3});
    cmp({15'h0, shutdown}, 16'h0000);
    host.xfer(16'h0000, 0, q);
    cmp(q, 16'h8007);
    cmp(16'(n_restart), 16'h0004);
    $display("mode test done");
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1;
    repeat (4) @(negedge clk);
    t_temp();
    t_mode();
    conclude();
  end
endmodule
